//--- hdl/psbf_pkg.sv
// shared constants and types for the public spanning tree frame filter
package psbf_pkg;

  // ********************************
  // register map (byte addresses)
  // ********************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SYMR   = 8'h04;
  localparam logic [7:0] ADDR_COST   = 8'h08;
  localparam logic [7:0] ADDR_PRIO   = 8'h0C;
  localparam logic [7:0] ADDR_NSI    = 8'h10;
  localparam logic [7:0] ADDR_MAC_LO = 8'h14;
  localparam logic [7:0] ADDR_MAC_HI = 8'h18;
  localparam logic [7:0] ADDR_STAT   = 8'h1C;
  localparam logic [7:0] ADDR_TIMERS = 8'h20;

  // field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_OVR_BIT  = 1;
  localparam int CTRL_HE_BIT   = 2;
  localparam int SYMR_BPS_LSB  = 16;
  localparam int STAT_BUSY_BIT = 24;

  // ********************************
  // values after reset
  // ********************************
  localparam logic        RST_EN       = 1'b1;
  localparam logic [15:0] RST_PRIO_CM  = 16'h9000;
  localparam logic [15:0] RST_PRIO_HE  = 16'h8000;
  localparam logic [15:0] RST_NSI_COST = 16'h000A;
  localparam logic [15:0] RST_SYM_KSYM = 16'h00A0;
  localparam logic [3:0]  RST_BPS      = 4'h2;
  localparam logic [7:0]  RST_MAX_AGE  = 8'h14;
  localparam logic [7:0]  RST_HELLO    = 8'h02;
  localparam logic [7:0]  RST_FWD_DLY  = 8'h0F;
  localparam logic [47:0] RST_MAC      = 48'h000000000000;

  // ********************************
  // frame layout
  // ********************************
  localparam logic [0:5][7:0] PUB_DA  = {8'h01, 8'hE0, 8'h2F, 8'h00, 8'h00, 8'h03};
  localparam logic [0:5][7:0] STD_DA  = {8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h00};
  localparam logic [0:7][7:0] PUB_SNAP = {8'hAA, 8'hAA, 8'h03, 8'h00,
                                          8'hE0, 8'h2F, 8'h73, 8'h74};
  localparam logic [0:2][7:0] STD_LLC = {8'h42, 8'h42, 8'h03};
  localparam logic [4:0]  POS_SA    = 5'h06;
  localparam logic [4:0]  POS_LEN   = 5'h0C;
  localparam logic [4:0]  POS_LLC   = 5'h0E;
  localparam logic [4:0]  POS_LLC_E = 5'h10;
  localparam logic [4:0]  POS_TYPE  = 5'h19;
  localparam logic [4:0]  HDR_LEN   = 5'h16;
  localparam logic [15:0] LEN_FIELD = 16'h002B;
  localparam logic [7:0]  TYPE_TCN  = 8'h80;

  // cost = 1000 Mbit / rate, rate in ksym/s times bits per symbol
  localparam logic [20:0] COST_NUM  = 21'h0F4240;
  localparam logic [4:0]  DIV_STEPS = 5'h15;
  localparam logic [15:0] COST_MAX  = 16'hFFFF;

  // ********************************
  // types
  // ********************************
  typedef struct packed {
    logic accept;
    logic relay_down;
    logic discard;
    logic bypass;
  } psbf_verdict_t;

  typedef struct packed {
    logic [15:0] prio;
    logic [15:0] path_cost;
    logic [15:0] nsi_cost;
    logic [7:0]  max_age;
    logic [7:0]  hello;
    logic [7:0]  fwd_delay;
  } psbf_stp_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } psbf_byte_t;

  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_BODY, TX_DRAIN} psbf_txst_t;

endpackage : psbf_pkg

//--- hdl/psbf_cost_div.sv
// serial divider that turns a symbol rate into a default path cost
`timescale 1ns/1ns
module psbf_cost_div
  import psbf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [19:0] divisor,
  output logic             busy,
  output logic             done,
  output logic [15:0]      quot
);

  logic [4:0]  cnt_q,  cnt_d;
  logic [20:0] rem_q,  rem_d;
  logic [20:0] num_q,  num_d;
  logic [19:0] dvs_q,  dvs_d;
  logic        done_q, done_d;
  logic [15:0] quot_q, quot_d;
  logic [20:0] r2;
  logic [20:0] num_sh;

  // ********************************
  // restoring division, rounded half up
  // ********************************
  always_comb begin
    cnt_d  = cnt_q;
    rem_d  = rem_q;
    num_d  = num_q;
    dvs_d  = dvs_q;
    done_d = 1'b0;
    quot_d = quot_q;
    r2     = {rem_q[19:0], num_q[20]};
    num_sh = {num_q[19:0], 1'b0};
    if (start) begin
      // adding half the divisor rounds 1562.5 up to 1563 as the table expects
      num_d = COST_NUM + {2'b00, divisor[19:1]};
      dvs_d = divisor;
      rem_d = '0;
      cnt_d = DIV_STEPS;
    end else if (cnt_q != 5'h00) begin
      if (r2 >= {1'b0, dvs_q}) begin
        rem_d = r2 - {1'b0, dvs_q};
        num_d = num_sh | 21'h000001;
      end else begin
        rem_d = r2;
        num_d = num_sh;
      end
      cnt_d = cnt_q - 5'h01;
      if (cnt_q == 5'h01) begin
        done_d = 1'b1;
        // a zero or tiny rate would overflow the field, so the cost saturates
        quot_d = (num_d[20:16] != 5'h00) ? COST_MAX : num_d[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      rem_q  <= '0;
      num_q  <= '0;
      dvs_q  <= '0;
      done_q <= 1'b0;
      quot_q <= COST_MAX;
    end else begin
      cnt_q  <= cnt_d;
      rem_q  <= rem_d;
      num_q  <= num_d;
      dvs_q  <= dvs_d;
      done_q <= done_d;
      quot_q <= quot_d;
    end
  end

  assign busy = (cnt_q != 5'h00);
  assign done = done_q;
  assign quot = quot_q;

  div_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !busy) |-> ##22 done)
    else $error("cost divider did not finish in 22 cycles");

endmodule : psbf_cost_div

//--- hdl/psbf_filter.sv
// public spanning tree frame filter, bpdu framer and parameter registers
// ********************************
// ********************************
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module psbf_filter
  import psbf_pkg::*;
#(
  parameter logic HEADEND = 1'b0
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [7:0]    paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_data,
  input  wire logic          rx_eop,
  input  wire logic          rx_upstream,
  output psbf_verdict_t      verdict,
  input  wire logic          req_valid,
  input  wire logic          req_tcn,
  output logic               req_ready,
  input  wire logic          pl_valid,
  input  wire psbf_byte_t    pl,
  output logic               pl_ready,
  output logic               tx_valid,
  output psbf_byte_t         tx,
  input  wire logic          tx_ready,
  output psbf_stp_cfg_t      stp_cfg
);

  localparam logic [15:0] PRIO_RST = HEADEND ? RST_PRIO_HE : RST_PRIO_CM;

  // ********************************
  // apb slave and parameter registers
  // ********************************
  logic          en_q, en_d, ovr_q, ovr_d;
  logic [15:0]   sym_q, sym_d, cost_q, cost_d, prio_q, prio_d, nsi_q, nsi_d;
  logic [3:0]    bps_q, bps_d;
  logic [47:0]   mac_q, mac_d;
  logic [7:0]    age_q, age_d, hello_q, hello_d, fdly_q, fdly_d;
  logic [31:0]   prdata_q, prdata_d, wmask, rd_word;
  logic          go_q, go_d, hit, wr;
  logic [7:0]    cnt_std_q, cnt_std_d, cnt_tcn_q, cnt_tcn_d, cnt_pub_q, cnt_pub_d;
  logic          div_busy, div_done;
  logic [15:0]   div_quot;
  logic [19:0]   div_in;
  logic          std_ev, tcn_ev, pub_ev;

  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wr    = psel && penable && pwrite;

  always_comb begin
    hit     = 1'b1;
    rd_word = '0;
    case (paddr)
      ADDR_CTRL:   rd_word = {29'h0, HEADEND, ovr_q, en_q};
      ADDR_SYMR:   rd_word = {12'h0, bps_q, sym_q};
      ADDR_COST:   rd_word = {16'h0, stp_cfg.path_cost};
      ADDR_PRIO:   rd_word = {16'h0, prio_q};
      ADDR_NSI:    rd_word = {16'h0, nsi_q};
      ADDR_MAC_LO: rd_word = mac_q[31:0];
      ADDR_MAC_HI: rd_word = {16'h0, mac_q[47:32]};
      ADDR_STAT:   rd_word = {7'h0, div_busy, cnt_pub_q, cnt_tcn_q, cnt_std_q};
      ADDR_TIMERS: rd_word = {8'h0, fdly_q, hello_q, age_q};
      default:     hit     = 1'b0;
    endcase
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] wd);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  always_comb begin
    logic [31:0] w;
    w         = '0;
    en_d      = en_q;
    ovr_d     = ovr_q;
    sym_d     = sym_q;
    bps_d     = bps_q;
    cost_d    = cost_q;
    prio_d    = prio_q;
    nsi_d     = nsi_q;
    mac_d     = mac_q;
    age_d     = age_q;
    hello_d   = hello_q;
    fdly_d    = fdly_q;
    go_d      = 1'b0;
    prdata_d  = (psel && !penable) ? rd_word : prdata_q;
    cnt_std_d = cnt_std_q + {7'h0, std_ev && (cnt_std_q != 8'hFF)};
    cnt_tcn_d = cnt_tcn_q + {7'h0, tcn_ev && (cnt_tcn_q != 8'hFF)};
    cnt_pub_d = cnt_pub_q + {7'h0, pub_ev && (cnt_pub_q != 8'hFF)};
    if (wr) begin
      case (paddr)
        ADDR_CTRL: begin
          w     = merge({30'h0, ovr_q, en_q}, wmask, pwdata);
          en_d  = w[CTRL_EN_BIT];
          ovr_d = w[CTRL_OVR_BIT];
        end
        ADDR_SYMR: begin
          w     = merge({12'h0, bps_q, sym_q}, wmask, pwdata);
          sym_d = w[15:0];
          bps_d = w[SYMR_BPS_LSB +: 4];
          go_d  = 1'b1;
        end
        ADDR_COST: begin
          w      = merge({16'h0, cost_q}, wmask, pwdata);
          cost_d = w[15:0];
          ovr_d  = 1'b1;
        end
        ADDR_PRIO: begin
          w      = merge({16'h0, prio_q}, wmask, pwdata);
          prio_d = w[15:0];
        end
        ADDR_NSI: begin
          w     = merge({16'h0, nsi_q}, wmask, pwdata);
          nsi_d = w[15:0];
        end
        ADDR_MAC_LO: mac_d[31:0] = merge(mac_q[31:0], wmask, pwdata);
        ADDR_MAC_HI: begin
          w            = merge({16'h0, mac_q[47:32]}, wmask, pwdata);
          mac_d[47:32] = w[15:0];
        end
        ADDR_TIMERS: begin
          w       = merge({8'h0, fdly_q, hello_q, age_q}, wmask, pwdata);
          age_d   = w[7:0];
          hello_d = w[15:8];
          fdly_d  = w[23:16];
        end
        default: w = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q      <= RST_EN;
      ovr_q     <= 1'b0;
      sym_q     <= RST_SYM_KSYM;
      bps_q     <= RST_BPS;
      cost_q    <= COST_MAX;
      prio_q    <= PRIO_RST;
      nsi_q     <= RST_NSI_COST;
      mac_q     <= RST_MAC;
      age_q     <= RST_MAX_AGE;
      hello_q   <= RST_HELLO;
      fdly_q    <= RST_FWD_DLY;
      go_q      <= 1'b1;
      prdata_q  <= '0;
      cnt_std_q <= '0;
      cnt_tcn_q <= '0;
      cnt_pub_q <= '0;
    end else begin
      en_q      <= en_d;
      ovr_q     <= ovr_d;
      sym_q     <= sym_d;
      bps_q     <= bps_d;
      cost_q    <= cost_d;
      prio_q    <= prio_d;
      nsi_q     <= nsi_d;
      mac_q     <= mac_d;
      age_q     <= age_d;
      hello_q   <= hello_d;
      fdly_q    <= fdly_d;
      go_q      <= go_d;
      prdata_q  <= prdata_d;
      cnt_std_q <= cnt_std_d;
      cnt_tcn_q <= cnt_tcn_d;
      cnt_pub_q <= cnt_pub_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  // widened first so the product cannot wrap at 16 bits
  assign div_in  = 20'(sym_q) * 20'(bps_q);

  // one divider serves both roles: the rate register holds upstream rate and
  // long-grant modulation on a modem, downstream rate and modulation on a head end
  psbf_cost_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (go_q),
    .divisor (div_in),
    .busy    (div_busy),
    .done    (div_done),
    .quot    (div_quot)
  );

  assign stp_cfg = '{prio:      prio_q,
                     path_cost: ovr_q ? cost_q : div_quot,
                     nsi_cost:  nsi_q,
                     max_age:   age_q,
                     hello:     hello_q,
                     fwd_delay: fdly_q};

  // ********************************
  // receive classifier
  // ********************************
  logic [4:0]    idx_q, idx_d;
  logic          dpub_q, dpub_d, dstd_q, dstd_d, snap_q, snap_d, llc_q, llc_d, tcn_q, tcn_d;
  psbf_verdict_t verdict_q, verdict_d;
  logic          is_pub, is_std, vtcn_q, vtcn_d;

  always_comb begin
    dpub_d    = dpub_q;
    dstd_d    = dstd_q;
    snap_d    = snap_q;
    llc_d     = llc_q;
    tcn_d     = tcn_q;
    idx_d     = idx_q;
    verdict_d = '0;
    vtcn_d    = 1'b0;
    if (rx_valid) begin
      if (idx_q < POS_SA) begin
        dpub_d = dpub_q && (rx_data == PUB_DA[idx_q[2:0]]);
        dstd_d = dstd_q && (rx_data == STD_DA[idx_q[2:0]]);
      end
      if (idx_q >= POS_LLC && idx_q < HDR_LEN) begin
        snap_d = snap_q && (rx_data == PUB_SNAP[3'(idx_q - POS_LLC)]);
      end
      if (idx_q >= POS_LLC && idx_q <= POS_LLC_E) begin
        llc_d = llc_q && (rx_data == STD_LLC[2'(idx_q - POS_LLC)]);
      end
      if (idx_q == POS_TYPE) begin
        tcn_d = (rx_data == TYPE_TCN);
      end
      idx_d = (idx_q == 5'h1F) ? idx_q : idx_q + 5'h01;
    end
    // both address and snap header must match before spanning tree sees the frame
    is_pub = en_q && dpub_d && snap_d && (idx_q >= POS_TYPE);
    is_std = en_q && dstd_d && llc_d && (idx_q >= POS_LLC_E);
    if (rx_valid && rx_eop) begin
      verdict_d.discard    = is_std || (is_pub && tcn_d);
      verdict_d.accept     = is_pub && !tcn_d;
      verdict_d.relay_down = is_pub && HEADEND && rx_upstream;
      verdict_d.bypass     = !is_std && !is_pub;
      // the type flag is cleared below, so the notice mark travels with the verdict
      vtcn_d               = is_pub && tcn_d;
      dpub_d = 1'b1;
      dstd_d = 1'b1;
      snap_d = 1'b1;
      llc_d  = 1'b1;
      tcn_d  = 1'b0;
      idx_d  = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q     <= '0;
      dpub_q    <= 1'b1;
      dstd_q    <= 1'b1;
      snap_q    <= 1'b1;
      llc_q     <= 1'b1;
      tcn_q     <= 1'b0;
      verdict_q <= '0;
      vtcn_q    <= 1'b0;
    end else begin
      idx_q     <= idx_d;
      dpub_q    <= dpub_d;
      dstd_q    <= dstd_d;
      snap_q    <= snap_d;
      llc_q     <= llc_d;
      tcn_q     <= tcn_d;
      verdict_q <= verdict_d;
      vtcn_q    <= vtcn_d;
    end
  end

  assign verdict = verdict_q;
  assign std_ev  = verdict_q.discard && !vtcn_q;
  assign pub_ev  = verdict_q.accept;

  // ********************************
  // transmit framer
  // ********************************
  psbf_txst_t st_q, st_d;
  logic [4:0] hidx_q, hidx_d;
  logic       txv_q, txv_d, adv, tcn_refuse;
  psbf_byte_t tx_q, tx_d;

  function automatic logic [7:0] hdr_byte(input logic [4:0] i, input logic [47:0] mac);
    logic [2:0] mb;
    mb = 3'(i - POS_SA);
    if (i < POS_SA)       hdr_byte = PUB_DA[i[2:0]];
    else if (i < POS_LEN) hdr_byte = mac[8*(5-mb) +: 8];
    else if (i == POS_LEN) hdr_byte = LEN_FIELD[15:8];
    else if (i < POS_LLC)  hdr_byte = LEN_FIELD[7:0];
    else                   hdr_byte = PUB_SNAP[3'(i - POS_LLC)];
  endfunction : hdr_byte

  assign adv = !txv_q || tx_ready;

  always_comb begin
    st_d       = st_q;
    hidx_d     = hidx_q;
    txv_d      = txv_q && !tx_ready;
    tx_d       = tx_q;
    pl_ready   = 1'b0;
    req_ready  = 1'b0;
    tcn_refuse = 1'b0;
    case (st_q)
      TX_IDLE: begin
        req_ready = en_q && !txv_q;
        if (req_valid && req_ready) begin
          // a notice request is swallowed with its payload, nothing reaches the wire
          tcn_refuse = req_tcn;
          st_d       = req_tcn ? TX_DRAIN : TX_HDR;
          hidx_d     = '0;
        end
      end
      TX_HDR: begin
        if (adv) begin
          txv_d  = 1'b1;
          tx_d   = '{data: hdr_byte(hidx_q, mac_q), last: 1'b0};
          hidx_d = hidx_q + 5'h01;
          if (hidx_q == HDR_LEN - 5'h01) st_d = TX_BODY;
        end
      end
      TX_BODY: begin
        pl_ready = adv;
        if (pl_valid && adv) begin
          txv_d = 1'b1;
          tx_d  = pl;
          if (pl.last) st_d = TX_IDLE;
        end
      end
      TX_DRAIN: begin
        pl_ready = 1'b1;
        if (pl_valid && pl.last) st_d = TX_IDLE;
      end
      default: st_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= TX_IDLE;
      hidx_q <= '0;
      txv_q  <= 1'b0;
      tx_q   <= '0;
    end else begin
      st_q   <= st_d;
      hidx_q <= hidx_d;
      txv_q  <= txv_d;
      tx_q   <= tx_d;
    end
  end

  assign tx_valid = txv_q;
  assign tx       = tx_q;
  assign tcn_ev   = tcn_refuse || vtcn_q;

  // ********************************
  // checks
  // ********************************
  tx_dest_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == TX_HDR && adv && hidx_q < POS_SA) |=> tx.data == PUB_DA[$past(hidx_q)])
    else $error("destination byte is not the public multicast address");

  tx_snap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == TX_HDR && adv && hidx_q >= POS_LLC)
      |=> tx.data == PUB_SNAP[3'($past(hidx_q) - POS_LLC)])
    else $error("header byte is not the public snap header");

  std_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_valid && rx_eop && is_std) |=> verdict.discard && !verdict.accept && !verdict.bypass)
    else $error("standard bpdu was not discarded");

  tcn_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && req_ready && req_tcn) |=> (!tx_valid && st_q == TX_DRAIN)[*2])
    else $error("notice request produced output");

  pub_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_valid && rx_eop && !(dpub_d && snap_d)) |=> !verdict.accept)
    else $error("frame accepted without both address and snap match");

  relay_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_valid && rx_eop && is_pub && rx_upstream) |=> verdict.relay_down == HEADEND)
    else $error("upstream public bpdu not relayed on head end");

  prio_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> stp_cfg.prio == PRIO_RST && stp_cfg.nsi_cost == RST_NSI_COST)
    else $error("priority or network-side cost default wrong after reset");

  cost_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (div_done && !ovr_q && !wr) |-> stp_cfg.path_cost == div_quot ##1 !div_busy)
    else $error("path cost does not follow derived value");

  cost_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == ADDR_COST && pstrb == 4'hF)
      |=> stp_cfg.path_cost == 16'($past(pwdata)) && ovr_q)
    else $error("written path cost not applied");

endmodule : psbf_filter

//--- dv/psbf_peer.sv
// partner bridge model: sinks the outgoing bpdu stream
`timescale 1ns/1ns
module psbf_peer
  import psbf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tx_valid,
  input  wire psbf_byte_t  tx,
  output logic             tx_ready,
  output logic [0:21][7:0] hdr,
  output logic [7:0]       frames
);
  int idx;
  // random stalls, about one cycle in four, force the framer to hold some bytes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      idx = 0;
      frames <= 8'h00;
      hdr <= '0;
    end else begin
      if (tx_valid && tx_ready) begin
        if (idx < 22) hdr[idx] <= tx.data;
        idx = tx.last ? 0 : idx + 1;
        if (tx.last) frames <= frames + 8'h01;
      end
      tx_ready <= ($urandom % 4) != 0;
    end
  end
endmodule : psbf_peer

//--- dv/psbf_filter_tb.sv
// self-checking bench for the public spanning tree frame filter
`timescale 1ns/1ns
module psbf_filter_tb;
  import psbf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, req_ready, pl_ready, tx_valid, tx_ready;
  logic rx_valid = 0, rx_eop = 0, rx_upstream = 0, req_valid = 0, req_tcn = 0, pl_valid = 0;
  logic [7:0] rx_data = 8'h00, frames;
  psbf_byte_t pl = '0, tx;
  psbf_verdict_t verdict;
  psbf_stp_cfg_t stp_cfg;
  psbf_verdict_t verdict_he;
  psbf_stp_cfg_t stp_cfg_he;
  logic [31:0] wv;
  logic u;
  logic [0:21][7:0] hdr;
  logic [7:0] f [0:25];
  int fail_count = 0, cmp_count = 0, k, b;
  always #25 pclk = ~pclk;
  psbf_filter DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eop(rx_eop), .rx_upstream(rx_upstream), .verdict(verdict), .req_valid(req_valid),
    .req_tcn(req_tcn), .req_ready(req_ready), .pl_valid(pl_valid), .pl(pl),
    .pl_ready(pl_ready), .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready),
    .stp_cfg(stp_cfg));
  psbf_peer peer (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx(tx),
    .tx_ready(tx_ready), .hdr(hdr), .frames(frames));
  // head-end role shares the bus and receive stream; its transmit side stays idle
  psbf_filter #(.HEADEND(1'b1)) DUT_HE (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(), .pready(), .pslverr(), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eop(rx_eop), .rx_upstream(rx_upstream), .verdict(verdict_he), .req_valid(1'b0),
    .req_tcn(1'b0), .req_ready(), .pl_valid(1'b0), .pl('0), .pl_ready(), .tx_valid(),
    .tx(), .tx_ready(1'b1), .stp_cfg(stp_cfg_he));
  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function automatic logic [15:0] cost(input int kk, input int bb);
    return 16'((2000000 + kk * bb) / (2 * kk * bb));
  endfunction : cost
  // fill a frame: public when p, else standard; t is the type byte; bad >= 0 spoils one byte
  task automatic frame(input bit p, input logic [7:0] t, input logic [3:0] x, input int bad);
    for (int i = 0; i < 26; i++) f[i] = 8'($urandom);
    for (int i = 0; i < 6; i++) f[i] = p ? PUB_DA[i] : STD_DA[i];
    for (int i = 0; i < 8; i++) if (p) f[14+i] = PUB_SNAP[i];
    for (int i = 0; i < 3; i++) if (!p) f[14+i] = STD_LLC[i];
    f[25] = p ? t : f[25];
    if (bad >= 0) f[bad] = f[bad] ^ 8'h01;
    for (int i = 0; i < 26; i++) begin
      @(posedge pclk);
      u = 1'($urandom);
      rx_valid <= 1; rx_data <= f[i]; rx_eop <= (i == 25); rx_upstream <= u;
    end
    @(posedge pclk);
    rx_valid <= 0;
    rx_eop <= 0;
    #1 chk("verdict", x, verdict);
    chk("verdict_he", x | {1'b0, u && p && (x != 4'b0001), 2'b00}, verdict_he);
  endtask : frame
  task automatic send(input logic topology_change_notice);
    @(posedge pclk);
    req_valid <= 1; req_tcn <= topology_change_notice;
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 0;
    for (int i = 0; i < 2; i++) begin
      pl_valid <= 1; pl <= '{data: 8'($urandom), last: (i == 1)};
      do @(posedge pclk); while (pl_ready !== 1'b1);
    end
    pl_valid <= 0;
    repeat (40) @(posedge pclk);
  endtask : send
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    #3000000;
    fail_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'hef51da06));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    repeat (30) @(posedge pclk);
    apb(0, ADDR_PRIO, 0);  chk("prio", 16'h9000, r[15:0]);
    apb(0, ADDR_TIMERS, 0); chk("timers", 24'h0F0214, r[23:0]);
    chk("prio_he", 16'h8000, stp_cfg_he.prio);
    chk("he_root", 1'b1, stp_cfg_he.prio < stp_cfg.prio);
    apb(0, ADDR_NSI, 0);   chk("nsi", 16'h000A, r[15:0]);
    apb(0, ADDR_COST, 0);  chk("cost0", 16'd3125, r[15:0]);
    apb(0, 8'hF0, 0);      chk("unmapped", 1'b1, e);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      k = 160 << (i / 2);
      b = (i % 2) ? 4 : 2;
      apb(1, ADDR_SYMR, {12'h0, 4'(b), 16'(k)});
      repeat (25) @(posedge pclk);
      apb(0, ADDR_COST, 0); chk("cost", cost(k, b), r[15:0]);
      chk("cfg_cost", cost(k, b), stp_cfg.path_cost);
      chk("he_cost", cost(k, b), stp_cfg_he.path_cost);
    end
    wv = 32'($urandom);
    apb(1, ADDR_PRIO, wv);
    apb(0, ADDR_PRIO, 0); chk("prio_wr", wv[15:0], r[15:0]);
    wv = 32'($urandom);
    apb(1, ADDR_COST, wv);
    apb(0, ADDR_COST, 0); chk("cost_wr", wv[15:0], r[15:0]);
    chk("cfg_ovr", wv[15:0], stp_cfg.path_cost);
    apb(1, ADDR_CTRL, 32'h1);
    @(posedge pclk);
    chk("cost_back", cost(k, b), stp_cfg.path_cost);
    $display("test cost done");
    frame(1, 8'h00, 4'b1000, -1);
    frame(0, 8'h00, 4'b0010, -1);
    frame(1, TYPE_TCN, 4'b0010, -1);
    frame(1, 8'h00, 4'b0001, 0);
    frame(1, 8'h00, 4'b0001, 17);
    apb(0, ADDR_STAT, 0); chk("stat", 32'h00010101, r);
    apb(1, ADDR_CTRL, 32'h0);
    frame(1, 8'h00, 4'b0001, -1);
    apb(1, ADDR_CTRL, 32'h1);
    $display("test rx done");
    send(0);
    chk("frames", 8'h01, frames);
    chk("da", 48'h01E02F000003, {hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5]});
    chk("snap", 64'hAAAA0300E02F7374, hdr[14:21]);
    send(1);
    chk("no_notice", 8'h01, frames);
    $display("test tx done");
    close_out();
  end
endmodule : psbf_filter_tb
